// ==== aocc_pkg.sv ====
// Package for the auxiliary output and clock configuration register bank
`default_nettype none
package aocc_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  OFS_AUX_CTRL    = 8'h10;
  localparam logic [7:0]  OFS_DEV_SET     = 8'h11;
  localparam logic [7:0]  OFS_CLK_SYNC    = 8'h12;
  localparam logic [7:0]  OFS_SUP_MON     = 8'h13;
  localparam logic [7:0]  RST_AUX_CTRL    = 8'h0a;
  localparam logic [7:0]  RST_DEV_SET     = 8'h3c;
  localparam logic [7:0]  RST_CLK_SYNC    = 8'h02;
  localparam logic [7:0]  RST_SUP_MON     = 8'h00;
  // Aux control fields
  localparam int          BIT_THIRD_SEL   = 5;
  localparam int          BIT_SECOND_SEL  = 4;
  localparam int          BIT_THIRD_OD    = 3;
  localparam int          BIT_GATE_LO     = 1;
  localparam int          BIT_THIRD_LVL   = 0;
  // Device settings fields
  localparam int          BIT_START_RNG   = 7;
  localparam int          BIT_SHUT_RNG    = 6;
  localparam int          BIT_CLK_PD      = 5;
  localparam int          BIT_ENABLE_ONE_PULLDOWN      = 2;
  localparam int          BIT_THERM_THR   = 1;
  localparam int          BIT_SPREAD      = 0;
  // Clock sync fields
  localparam int          BIT_PLL_EN      = 6;
  localparam int          BIT_FRAC_DIV    = 5;
  localparam logic [4:0]  FREQ_CODE_MAX   = 5'h17;
  // Supply monitor fields
  localparam int          BIT_MON_WINDOW  = 6;
  // Delay step units, in microseconds
  localparam int          STEP_FINE_US    = 500;
  localparam int          STEP_COARSE_US  = 1000;
  // One-time memory load: a single cycle after reset release
  localparam int          OTP_LOAD_CYCLES = 1;
  typedef enum logic [1:0] {
    CLK_INTERNAL,
    CLK_WAIT_LOCK,
    CLK_EXTERNAL
  } aocc_clk_e;
endpackage : aocc_pkg
`default_nettype wire

// ==== aocc_regs.sv ====
// Configuration register bank with pin muxing and clock source control
`default_nettype none
module aocc_regs (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [aocc_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [aocc_pkg::DATA_W-1:0]   regWdata,
  input  wire logic                          regWrite,
  input  wire logic                          regRead,
  output logic      [aocc_pkg::DATA_W-1:0]   regRdata,
  input  wire logic [31:0]                   otpDefaults,
  input  wire logic                          enableInputOne,
  input  wire logic                          enableInputTwo,
  input  wire logic                          enableInputThree,
  input  wire logic                          extClockPresent,
  input  wire logic                          pllLocked,
  input  wire logic                          powerGoodSecondIn,
  output logic                               thirdAuxOutput,
  output logic                               thirdAuxOutputEn_n,
  output logic                               secondPinLevel,
  output logic                               secondPinIsOutput,
  output logic                               clockPinIsInput,
  output logic      [3:0]                    pulldownEnable,
  output logic                               thermalWarnHigh,
  output logic                               spreadSpectrumEnable,
  output logic      [15:0]                   startupStepUs,
  output logic      [15:0]                   shutdownStepUs,
  output logic                               pllEnable,
  output logic                               useExternalClock,
  output logic      [5:0]                    extClockMhz,
  output logic                               clockEventIrq,
  output logic                               monitorWindowMode,
  output logic      [5:0]                    monitorEnable,
  output logic                               monitorChangeIrq
);
  import aocc_pkg::*;

  logic [7:0] regs_reg [4];
  logic [7:0] regs_next [4];
  logic       loaded_reg;
  logic       loaded_next;
  logic [7:0] rdata_next;
  aocc_clk_e  clkState_reg;
  aocc_clk_e  clkState_next;
  logic       extSeen_reg;
  logic       extSeen_next;
  logic [3:0] outs_next;

  function automatic logic [2:0] reg_index(input logic [7:0] a);
    case (a)
      OFS_AUX_CTRL: reg_index = 3'd0;
      OFS_DEV_SET:  reg_index = 3'd1;
      OFS_CLK_SYNC: reg_index = 3'd2;
      OFS_SUP_MON:  reg_index = 3'd3;
      default:      reg_index = 3'd4;
    endcase
  endfunction : reg_index

  function automatic logic [15:0] step_us(input logic coarse);
    step_us = coarse ? 16'(STEP_COARSE_US) : 16'(STEP_FINE_US);
  endfunction : step_us

  logic [2:0] wIdx;
  logic       extAvail;
  logic       gateEn;
  assign wIdx = reg_index(regAddr);
  assign extAvail = extClockPresent && !regs_reg[0][BIT_THIRD_SEL];

  // Register storage and one-time default load
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      regs_next[i] = regs_reg[i];
    end
    loaded_next = 1'b1;
    if (!loaded_reg) begin
      for (int i = 0; i < 4; i++) begin
        regs_next[i] = otpDefaults[i*8 +: 8];
      end
    end else if (regWrite && wIdx < 3'd4) begin
      regs_next[wIdx[1:0]] = regWdata;
    end
    rdata_next = 8'h00;
    if (regRead && wIdx < 3'd4) begin
      rdata_next = regs_reg[wIdx[1:0]];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      regs_reg[0] <= RST_AUX_CTRL;
      regs_reg[1] <= RST_DEV_SET;
      regs_reg[2] <= RST_CLK_SYNC;
      regs_reg[3] <= RST_SUP_MON;
      loaded_reg  <= 1'b0;
      regRdata    <= 8'h00;
    end else begin
      regs_reg   <= regs_next;
      loaded_reg <= loaded_next;
      regRdata   <= rdata_next;
    end
  end

  // Gate select for the third output
  always_comb begin
    case (regs_reg[0][2:1])
      2'h0:    gateEn = 1'b1;
      2'h1:    gateEn = enableInputOne;
      2'h2:    gateEn = enableInputTwo;
      2'h3:    gateEn = enableInputThree;
      default: gateEn = 1'b1;
    endcase
  end

  // Pin outputs
  logic thirdLvl;
  logic thirdDrive;
  assign thirdLvl = regs_reg[0][BIT_THIRD_LVL] && gateEn;
  always_comb begin
    outs_next[0] = thirdLvl;
    thirdDrive   = 1'b0;
    if (regs_reg[0][BIT_THIRD_SEL]) begin
      thirdDrive = regs_reg[0][BIT_THIRD_OD] ? !thirdLvl : 1'b1;
    end
    outs_next[1] = !thirdDrive;
    outs_next[2] = regs_reg[0][BIT_SECOND_SEL] ? regs_reg[0][BIT_THIRD_LVL] : powerGoodSecondIn;
    outs_next[3] = !regs_reg[0][BIT_THIRD_SEL];
  end

  // Clock source state machine
  always_comb begin
    clkState_next = clkState_reg;
    extSeen_next  = extAvail;
    case (clkState_reg)
      CLK_INTERNAL: begin
        if (regs_reg[2][BIT_PLL_EN] && extAvail) begin
          clkState_next = CLK_WAIT_LOCK;
        end
      end
      CLK_WAIT_LOCK: begin
        if (!regs_reg[2][BIT_PLL_EN] || !extAvail) begin
          clkState_next = CLK_INTERNAL;
        end else if (pllLocked) begin
          clkState_next = CLK_EXTERNAL;
        end
      end
      CLK_EXTERNAL: begin
        if (!regs_reg[2][BIT_PLL_EN] || !extAvail) begin
          clkState_next = CLK_INTERNAL;
        end
      end
      default: clkState_next = CLK_INTERNAL;
    endcase
  end

  logic [5:0] monPrev_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      clkState_reg         <= CLK_INTERNAL;
      extSeen_reg          <= 1'b0;
      thirdAuxOutput       <= 1'b0;
      thirdAuxOutputEn_n   <= 1'b1;
      secondPinLevel       <= 1'b0;
      clockPinIsInput      <= 1'b1;
      secondPinIsOutput    <= 1'b0;
      pulldownEnable       <= 4'h0;
      thermalWarnHigh      <= 1'b0;
      spreadSpectrumEnable <= 1'b0;
      startupStepUs        <= 16'h0000;
      shutdownStepUs       <= 16'h0000;
      pllEnable            <= 1'b0;
      useExternalClock     <= 1'b0;
      extClockMhz          <= 6'h00;
      clockEventIrq        <= 1'b0;
      monitorWindowMode    <= 1'b0;
      monitorEnable        <= 6'h00;
      monPrev_reg          <= 6'h00;
      monitorChangeIrq     <= 1'b0;
    end else begin
      clkState_reg         <= clkState_next;
      extSeen_reg          <= extSeen_next;
      thirdAuxOutput       <= outs_next[0];
      thirdAuxOutputEn_n   <= outs_next[1];
      secondPinLevel       <= outs_next[2];
      clockPinIsInput      <= outs_next[3];
      secondPinIsOutput    <= regs_reg[0][BIT_SECOND_SEL];
      pulldownEnable       <= regs_reg[1][BIT_CLK_PD:BIT_ENABLE_ONE_PULLDOWN];
      thermalWarnHigh      <= regs_reg[1][BIT_THERM_THR];
      spreadSpectrumEnable <= regs_reg[1][BIT_SPREAD];
      startupStepUs        <= step_us(regs_reg[1][BIT_START_RNG]);
      shutdownStepUs       <= step_us(regs_reg[1][BIT_SHUT_RNG]);
      pllEnable            <= regs_reg[2][BIT_PLL_EN];
      useExternalClock     <= (clkState_next == CLK_EXTERNAL);
      extClockMhz          <= {1'b0, regs_reg[2][4:0]} + 6'h01;
      clockEventIrq        <= regs_reg[2][BIT_PLL_EN] && (extAvail != extSeen_reg);
      monitorWindowMode    <= regs_reg[3][BIT_MON_WINDOW];
      monitorEnable        <= regs_reg[3][5:0];
      monPrev_reg          <= loaded_reg ? regs_reg[3][5:0] : otpDefaults[29:24];
      monitorChangeIrq     <= loaded_reg && (regs_reg[3][5:0] != monPrev_reg);
    end
  end

  a_clock_event_pulse: assert property (@(posedge clk) disable iff (rst)
    (regs_reg[2][BIT_PLL_EN] && $changed(extAvail)) |=> clockEventIrq)
    else $error("clock event interrupt missing");
  a_pll_off_internal: assert property (@(posedge clk) disable iff (rst)
    !regs_reg[2][BIT_PLL_EN] |=> !useExternalClock)
    else $error("external clock used with pll off");
  a_pin_as_output: assert property (@(posedge clk) disable iff (rst)
    regs_reg[0][BIT_THIRD_SEL] |=> ##1 !useExternalClock)
    else $error("clock used while pin is output");
  a_gate_level_off: assert property (@(posedge clk) disable iff (rst)
    !regs_reg[0][BIT_THIRD_LVL] |=> !thirdAuxOutput)
    else $error("third output high with level zero");
  a_gate_enable_one: assert property (@(posedge clk) disable iff (rst)
    (regs_reg[0][2:1] == 2'h1 && !enableInputOne) |=> !thirdAuxOutput)
    else $error("gate by enable one ignored");
  a_od_no_high: assert property (@(posedge clk) disable iff (rst)
    (regs_reg[0][BIT_THIRD_OD] && regs_reg[0][BIT_THIRD_SEL] && thirdLvl) |=> thirdAuxOutputEn_n)
    else $error("open drain drove high");
  a_freq_plus_one: assert property (@(posedge clk) disable iff (rst)
    loaded_reg |=> extClockMhz == 6'($past(regs_reg[2][4:0]) + 1))
    else $error("frequency decode wrong");
  a_step_coarse: assert property (@(posedge clk) disable iff (rst)
    regs_reg[1][BIT_START_RNG] |=> startupStepUs == 16'(STEP_COARSE_US))
    else $error("startup step wrong");
  a_otp_load: assert property (@(posedge clk)
    ($fell(rst)) |=> regs_reg[0] == $past(otpDefaults[7:0]))
    else $error("defaults not loaded");

  a_clock_pin_out: assert property (@(posedge clk) disable iff (rst)
    regs_reg[0][BIT_THIRD_SEL] |=> !clockPinIsInput)
    else $error("clock pin still input");

  a_clock_pin_in: assert property (@(posedge clk) disable iff (rst)
    !regs_reg[0][BIT_THIRD_SEL] |=> (clockPinIsInput && thirdAuxOutputEn_n))
    else $error("clock pin driven");

  a_second_pin_pg: assert property (@(posedge clk) disable iff (rst)
    !regs_reg[0][BIT_SECOND_SEL] |=> (!secondPinIsOutput && secondPinLevel == $past(powerGoodSecondIn)))
    else $error("second pin not power good");

  a_second_pin_out: assert property (@(posedge clk) disable iff (rst)
    regs_reg[0][BIT_SECOND_SEL] |=> (secondPinIsOutput && secondPinLevel == $past(regs_reg[0][BIT_THIRD_LVL])))
    else $error("second pin not output");

  a_push_pull_drive: assert property (@(posedge clk) disable iff (rst)
    (regs_reg[0][BIT_THIRD_SEL] && !regs_reg[0][BIT_THIRD_OD]) |=> !thirdAuxOutputEn_n)
    else $error("push pull not driving");

  a_od_drive_low: assert property (@(posedge clk) disable iff (rst)
    (regs_reg[0][BIT_THIRD_SEL] && regs_reg[0][BIT_THIRD_OD] && !thirdLvl) |=> (!thirdAuxOutputEn_n && !thirdAuxOutput))
    else $error("open drain not pulling low");

  a_gate_enable_two: assert property (@(posedge clk) disable iff (rst)
    (regs_reg[0][2:1] == 2'h2 && !enableInputTwo) |=> !thirdAuxOutput)
    else $error("gate by enable two ignored");

  a_gate_enable_three: assert property (@(posedge clk) disable iff (rst)
    (regs_reg[0][2:1] == 2'h3 && !enableInputThree) |=> !thirdAuxOutput)
    else $error("gate by enable three ignored");

  a_level_only: assert property (@(posedge clk) disable iff (rst)
    (regs_reg[0][2:1] == 2'h0 && regs_reg[0][BIT_THIRD_LVL]) |=> thirdAuxOutput)
    else $error("level bit alone ignored");

  a_step_fine: assert property (@(posedge clk) disable iff (rst)
    !regs_reg[1][BIT_START_RNG] |=> startupStepUs == 16'(STEP_FINE_US))
    else $error("startup fine step wrong");

  a_shut_coarse: assert property (@(posedge clk) disable iff (rst)
    regs_reg[1][BIT_SHUT_RNG] |=> shutdownStepUs == 16'(STEP_COARSE_US))
    else $error("shutdown coarse step wrong");

  a_shut_fine: assert property (@(posedge clk) disable iff (rst)
    !regs_reg[1][BIT_SHUT_RNG] |=> shutdownStepUs == 16'(STEP_FINE_US))
    else $error("shutdown fine step wrong");

  a_pulldown_map: assert property (@(posedge clk) disable iff (rst)
    loaded_reg |=> pulldownEnable == $past(regs_reg[1][BIT_CLK_PD:BIT_ENABLE_ONE_PULLDOWN]))
    else $error("pull-down map wrong");

  a_therm_spread: assert property (@(posedge clk) disable iff (rst)
    loaded_reg |=> {thermalWarnHigh, spreadSpectrumEnable} == $past(regs_reg[1][1:0]))
    else $error("thermal or spread wrong");

  // Clock source hand-over
  sequence s_lock_ready;
    regs_reg[2][BIT_PLL_EN] && extAvail && pllLocked && clkState_reg == CLK_WAIT_LOCK;
  endsequence
  sequence s_clock_lost;
    regs_reg[2][BIT_PLL_EN] && !extAvail;
  endsequence

  a_lock_switch: assert property (@(posedge clk) disable iff (rst)
    s_lock_ready |=> useExternalClock)
    else $error("external clock not taken");

  a_lost_fallback: assert property (@(posedge clk) disable iff (rst)
    s_clock_lost |=> !useExternalClock)
    else $error("lost clock still used");

  a_irq_quiet_off: assert property (@(posedge clk) disable iff (rst)
    !regs_reg[2][BIT_PLL_EN] |=> !clockEventIrq)
    else $error("clock event with pll off");

  a_window_mode: assert property (@(posedge clk) disable iff (rst)
    loaded_reg |=> monitorWindowMode == $past(regs_reg[3][BIT_MON_WINDOW]))
    else $error("window mode wrong");

  a_monitor_change: assert property (@(posedge clk) disable iff (rst)
    (loaded_reg && $past(loaded_reg) && $changed(regs_reg[3][5:0])) |=> monitorChangeIrq)
    else $error("monitor change interrupt missing");

  a_no_load_event: assert property (@(posedge clk) disable iff (rst)
    (loaded_reg && !$past(loaded_reg)) |=> !monitorChangeIrq)
    else $error("monitor event on default load");

  a_read_unmapped: assert property (@(posedge clk) disable iff (rst)
    (regRead && wIdx == 3'h4) |=> regRdata == 8'h00)
    else $error("unmapped read not zero");

  a_read_data: assert property (@(posedge clk) disable iff (rst)
    (regRead && wIdx < 3'h4) |=> regRdata == $past(regs_reg[wIdx[1:0]]))
    else $error("read data wrong");
endmodule : aocc_regs
`default_nettype wire

// ==== aocc_far_side.sv ====
// Far-side model: clock source, enable drivers, power-good level
`default_nettype none
module aocc_far_side (
  input  wire logic       clk,
  input  wire logic       srcOn,
  input  wire logic [2:0] enLevels,
  input  wire logic       pgLevel,
  input  wire logic       pllEnable,
  output logic            extClockPresent,
  output logic            pllLocked,
  output logic [2:0]      enPins,
  output logic            pgOut
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] lockCnt = 3'h0;
  assign extClockPresent = srcOn;
  assign enPins          = enLevels;
  assign pgOut           = pgLevel;
  // Lock needs four cycles of a present clock with the loop on
  always @(posedge clk) begin
    if (!(srcOn && pllEnable)) lockCnt <= 3'h0;
    else if (lockCnt != 3'h4) lockCnt <= lockCnt + 3'h1;
  end
  assign pllLocked = (lockCnt == 3'h4);
endmodule : aocc_far_side
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the configuration register bank
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import aocc_pkg::*;
  logic clk = 0, rst = 1, regWrite = 0, regRead = 0, srcOn = 0, pgLevel = 0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, d;
  logic [31:0] otpDefaults = {RST_SUP_MON, RST_CLK_SYNC, RST_DEV_SET, RST_AUX_CTRL};
  logic [2:0] enLevels = 3'h5, enPins;
  logic ext, lock, pg, tOut, tEn_n, sLvl, sOut, cIn, therm, spread, pllEn, useExt, cIrq, win, mIrq;
  logic [3:0] pd;
  logic [15:0] upUs, dnUs;
  logic [5:0] mhz, monEn;
  int num_errors = 0, n_checks = 0, cIrqs = 0, mIrqs = 0, b;
  aocc_regs u_aocc_regs (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .otpDefaults(otpDefaults), .enableInputOne(enPins[0]),
    .enableInputTwo(enPins[1]), .enableInputThree(enPins[2]), .extClockPresent(ext), .pllLocked(lock),
    .powerGoodSecondIn(pg), .thirdAuxOutput(tOut), .thirdAuxOutputEn_n(tEn_n), .secondPinLevel(sLvl),
    .secondPinIsOutput(sOut), .clockPinIsInput(cIn), .pulldownEnable(pd), .thermalWarnHigh(therm),
    .spreadSpectrumEnable(spread), .startupStepUs(upUs), .shutdownStepUs(dnUs), .pllEnable(pllEn),
    .useExternalClock(useExt), .extClockMhz(mhz), .clockEventIrq(cIrq), .monitorWindowMode(win),
    .monitorEnable(monEn), .monitorChangeIrq(mIrq));
  aocc_far_side u_aocc_far_side (.clk(clk), .srcOn(srcOn), .enLevels(enLevels), .pgLevel(pgLevel),
    .pllEnable(pllEn), .extClockPresent(ext), .pllLocked(lock), .enPins(enPins), .pgOut(pg));
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cIrq === 1'b1) cIrqs <= cIrqs + 1;
    if (mIrq === 1'b1) mIrqs <= mIrqs + 1;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    regWrite <= 1'b1; regAddr <= a; regWdata <= v;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRead <= 1'b1; regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk("readback", {8'h00, regRdata}, {8'h00, exp});
  endtask : rd
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n
  task automatic do_reset(input logic [31:0] otp);
    @(posedge clk);
    otpDefaults <= otp; rst <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("drive off in reset", {15'h0, tEn_n}, 16'h1);
    @(posedge clk) rst <= 1'b0;
    @(posedge clk);
  endtask : do_reset
  task automatic t_reset_map;
    for (int i = 0; i < 4; i++) rd(OFS_AUX_CTRL + 8'(i), otpDefaults[8*i +: 8]);
    rd(8'h14, 8'h00);
    rd(8'h0f, 8'h00);
    chk("clock pin input", {15'h0, cIn}, 16'h1);
    chk("pulldowns", {12'h0, pd}, 16'hf);
    chk("ext mhz", {10'h0, mhz}, 16'h3);
  endtask : t_reset_map
  task automatic t_pin_mux;
    for (int g = 0; g < 4; g++) begin
      wr(OFS_AUX_CTRL, 8'h31 | 8'(g << 1));
      wait_n(2);
      chk("third level", {15'h0, tOut}, {15'h0, (g == 0) ? 1'b1 : enLevels[g-1]});
      chk("push-pull drive", {15'h0, tEn_n}, 16'h0);
      chk("clock pin input", {15'h0, cIn}, 16'h0);
      chk("second pin", {14'h0, sOut, sLvl}, 16'h3);
    end
    wr(OFS_AUX_CTRL, 8'h38);
    wait_n(2);
    chk("od low drives", {14'h0, tOut, tEn_n}, 16'h0);
    wr(OFS_AUX_CTRL, 8'h39);
    pgLevel <= 1'b1;
    wait_n(2);
    chk("od high releases", {15'h0, tEn_n}, 16'h1);
    wr(OFS_AUX_CTRL, 8'hc0);
    wait_n(2);
    chk("pg routed", {13'h0, cIn, sOut, sLvl}, 16'h5);
    chk("no drive as clock", {15'h0, tEn_n}, 16'h1);
    rd(OFS_AUX_CTRL, 8'hc0);
    wr(OFS_AUX_CTRL, RST_AUX_CTRL);
  endtask : t_pin_mux
  task automatic t_dev_settings;
    logic [7:0] vals [2] = '{8'h43, 8'h94};
    foreach (vals[i]) begin
      wr(OFS_DEV_SET, vals[i]);
      wait_n(2);
      chk("startup step", upUs, vals[i][7] ? 16'(STEP_COARSE_US) : 16'(STEP_FINE_US));
      chk("shutdown step", dnUs, vals[i][6] ? 16'(STEP_COARSE_US) : 16'(STEP_FINE_US));
      chk("pulldowns", {12'h0, pd}, {12'h0, vals[i][5:2]});
      chk("therm spread", {14'h0, therm, spread}, {14'h0, vals[i][1:0]});
      rd(OFS_DEV_SET, vals[i]);
    end
  endtask : t_dev_settings
  task automatic t_clock_sync;
    @(posedge clk);
    srcOn <= 1'b1;
    wr(OFS_CLK_SYNC, 8'h17);
    wait_n(20);
    chk("pll off", {8'h0, pllEn, useExt, mhz}, 16'h18);
    wr(OFS_CLK_SYNC, 8'h57);
    for (int i = 0; i < 50 && useExt !== 1'b1; i++) wait_n(1);
    chk("lock to source", {15'h0, useExt}, 16'h1);
    b = cIrqs;
    @(posedge clk);
    srcOn <= 1'b0;
    wait_n(20);
    chk("source lost", {15'h0, useExt}, 16'h0);
    @(posedge clk);
    srcOn <= 1'b1;
    wait_n(20);
    chk("source events", 16'(cIrqs - b), 16'h2);
    wr(OFS_AUX_CTRL, 8'h20);
    wait_n(20);
    chk("pin as output", {15'h0, useExt}, 16'h0);
    wr(OFS_AUX_CTRL, RST_AUX_CTRL);
    wr(OFS_CLK_SYNC, 8'h17);
    wr(OFS_CLK_SYNC, 8'h80);
    wait_n(2);
    chk("code zero", {10'h0, mhz}, 16'h1);
    rd(OFS_CLK_SYNC, 8'h80);
  endtask : t_clock_sync
  task automatic t_monitor;
    b = mIrqs;
    wr(OFS_SUP_MON, 8'h7f);
    wait_n(2);
    chk("monitor set", {9'h0, win, monEn}, 16'h7f);
    wr(OFS_SUP_MON, 8'h40);
    wr(OFS_SUP_MON, 8'hc0);
    wait_n(4);
    chk("monitor cleared", {9'h0, win, monEn}, 16'h40);
    chk("change events", 16'(mIrqs - b), 16'h2);
    rd(OFS_SUP_MON, 8'hc0);
  endtask : t_monitor
  task automatic t_otp_load;
    b = mIrqs;
    do_reset(32'h4117c335);
    for (int i = 0; i < 4; i++) rd(OFS_AUX_CTRL + 8'(i), otpDefaults[8*i +: 8]);
    chk("no load events", 16'(mIrqs - b), 16'h0);
    chk("otp step", upUs, 16'(STEP_COARSE_US));
  endtask : t_otp_load
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    do_reset(otpDefaults);
    t_reset_map();
    t_pin_mux();
    t_dev_settings();
    t_clock_sync();
    t_monitor();
    t_otp_load();
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
